// [src/eprom_programmer.v]
// host-side programmer driving a byte-wide eprom port with the fast algorithm
// assumes cmd inputs come from logic on clk; data lines resolved by the bench
`timescale 1ns/1ns
`include "prog_port_consts.vh"
// Operation
// - eight-bit parallel data, bit 7 high
// - word load sends upper byte first
// - program: select low, read high, strobe pulse
// - address and data stable around strobe
// - each prime pulse lasts 1 ms
// - verify read after every prime pulse
// - retry prime pulse, fifteen at most
// - final pulse 4 ms times prime count
// - any address order accepted
// - strobes active low, data is write value
// - full pass rechecked at normal conditions; not done here, only read commands read back
module eprom_programmer
#(
    parameter PRIME_LEN = `PRIME_CYCLES,
    parameter FINAL_LEN = `FINAL_CYCLES
)
(
    input  wire        clk,
    input  wire        resetn,
    input  wire        cmd_valid,
    input  wire [1:0]  cmd_op,
    input  wire [12:0] cmd_addr,
    input  wire [15:0] cmd_data,
    output reg         cmd_ready_r,
    output reg         done_r,
    output reg         fail_r,
    output reg  [15:0] rdata_r,
    output reg  [3:0]  prime_count_r,
    output reg  [12:0] byte_address_lines_r,
    output reg  [7:0]  byte_data_out_r,
    output reg         byte_data_oe_n_r,
    input  wire [7:0]  byte_data_lines_in,
    output reg         array_select_n_r,
    output reg         read_select_n_r,
    output reg         write_strobe_n_r,
    output reg         test_mode_select_r,
    output reg         device_reset_input_r,
    output reg         oscillator_input_r
);
    // cmd_op: 0 program byte, 1 read byte, 2 program word, 3 read word
    localparam S_IDLE   = 4'd0;
    localparam S_SETUP  = 4'd1;
    localparam S_PRIME  = 4'd2;
    localparam S_VSET   = 4'd3;
    localparam S_VREAD  = 4'd4;
    localparam S_FINAL  = 4'd5;
    localparam S_RSET   = 4'd6;
    localparam S_RREAD  = 4'd7;
    localparam S_NEXT   = 4'd8;
    localparam S_WAIT   = 4'd9;

    reg [3:0]  state_r;
    reg [3:0]  ret_r;
    reg [7:0]  wait_r;
    reg [7:0]  target_r;
    reg [7:0]  lo_byte_r;
    reg        word_r;
    reg        second_r;
    reg        is_prog_r;
    reg        tstart_r;
    reg [31:0] tlen_r;
    reg [7:0]  s1_r;
    reg [7:0]  s2_r;
    reg [7:0]  s3_r;
    reg [7:0]  sampled_r;
    wire       tbusy;

    pulse_timer u_timer
    (
        .clk    (clk),
        .resetn (resetn),
        .start  (tstart_r),
        .length (tlen_r),
        .busy_r (tbusy)
    );

    // data lines arrive from the pins: three-stage, accept once stages 2 and 3 agree
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            s1_r      <= `ERASED_BYTE;
            s2_r      <= `ERASED_BYTE;
            s3_r      <= `ERASED_BYTE;
            sampled_r <= `ERASED_BYTE;
        end
        else
        begin
            s1_r <= byte_data_lines_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r)
                sampled_r <= s3_r;
        end
    end

    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_r              <= S_IDLE;
            ret_r                <= S_IDLE;
            wait_r               <= 8'h00;
            target_r             <= `ERASED_BYTE;
            lo_byte_r            <= `ERASED_BYTE;
            word_r               <= 1'b0;
            second_r             <= 1'b0;
            is_prog_r            <= 1'b0;
            tstart_r             <= 1'b0;
            tlen_r               <= 32'h0000_0000;
            cmd_ready_r          <= 1'b1;
            done_r               <= 1'b0;
            fail_r               <= 1'b0;
            rdata_r              <= 16'h0000;
            prime_count_r        <= 4'h0;
            byte_address_lines_r <= 13'h0000;
            byte_data_out_r      <= `ERASED_BYTE;
            byte_data_oe_n_r     <= 1'b1;
            array_select_n_r     <= 1'b1;
            read_select_n_r      <= 1'b1;
            write_strobe_n_r     <= 1'b1;
            test_mode_select_r   <= 1'b0;
            device_reset_input_r <= 1'b0;
            oscillator_input_r   <= 1'b0;
        end
        else
        begin
            tstart_r             <= 1'b0;
            done_r               <= 1'b0;
            // held low for every mode
            test_mode_select_r   <= 1'b0;
            device_reset_input_r <= 1'b0;
            oscillator_input_r   <= 1'b0;
            case (state_r)
                S_IDLE:
                begin
                    array_select_n_r <= 1'b1;
                    byte_data_oe_n_r <= 1'b1;
                    if (cmd_valid && cmd_ready_r)
                    begin
                        // any address order is fine
                        cmd_ready_r          <= 1'b0;
                        fail_r               <= 1'b0;
                        word_r               <= cmd_op[1];
                        is_prog_r            <= ~cmd_op[0];
                        second_r             <= 1'b0;
                        prime_count_r        <= 4'h0;
                        lo_byte_r            <= cmd_data[7:0];
                        // word: upper byte at even address first
                        byte_address_lines_r <= cmd_op[1] ? {cmd_addr[12:1], 1'b0} : cmd_addr;
                        target_r             <= cmd_op[1] ? cmd_data[15:8] : cmd_data[7:0];
                        wait_r               <= `SETUP_CYCLES;
                        state_r              <= cmd_op[0] ? S_RSET : S_SETUP;
                    end
                end
                S_SETUP:
                begin
                    // drive address and data ahead of the strobe
                    array_select_n_r <= 1'b0;
                    read_select_n_r  <= 1'b1;
                    byte_data_out_r  <= target_r;
                    byte_data_oe_n_r <= 1'b0;
                    if (wait_r == 8'h00)
                    begin
                        write_strobe_n_r <= 1'b0;
                        tlen_r           <= PRIME_LEN;
                        tstart_r         <= 1'b1;
                        prime_count_r    <= prime_count_r + 4'h1;
                        state_r          <= S_PRIME;
                    end
                    else
                        wait_r <= wait_r - 8'h01;
                end
                S_PRIME:
                begin
                    if (!tstart_r && !tbusy)
                    begin
                        write_strobe_n_r <= 1'b1;
                        wait_r           <= `SETUP_CYCLES;
                        state_r          <= S_VSET;
                    end
                end
                S_VSET:
                begin
                    // release the bus before opening the read
                    byte_data_oe_n_r <= 1'b1;
                    if (wait_r == 8'h00)
                    begin
                        read_select_n_r <= 1'b0;
                        wait_r          <= `READ_CYCLES;
                        state_r         <= S_VREAD;
                    end
                    else
                        wait_r <= wait_r - 8'h01;
                end
                S_VREAD:
                begin
                    // read long enough for the three-stage sampler to settle
                    if (wait_r == 8'h00)
                    begin
                        read_select_n_r <= 1'b1;
                        wait_r          <= `SETUP_CYCLES;
                        if (sampled_r == target_r)
                        begin
                            byte_data_out_r  <= target_r;
                            byte_data_oe_n_r <= 1'b0;
                            tlen_r           <= FINAL_LEN * prime_count_r;
                            ret_r            <= S_FINAL;
                            state_r          <= S_WAIT;
                        end
                        else if (prime_count_r == `MAX_PRIME)
                        begin
                            fail_r  <= 1'b1;
                            state_r <= S_NEXT;
                        end
                        else
                            state_r <= S_SETUP;
                    end
                    else
                        wait_r <= wait_r - 8'h01;
                end
                S_WAIT:
                begin
                    if (wait_r == 8'h00)
                    begin
                        write_strobe_n_r <= 1'b0;
                        tstart_r         <= 1'b1;
                        state_r          <= ret_r;
                    end
                    else
                        wait_r <= wait_r - 8'h01;
                end
                S_FINAL:
                begin
                    if (!tstart_r && !tbusy)
                    begin
                        write_strobe_n_r <= 1'b1;
                        state_r          <= S_NEXT;
                    end
                end
                S_RSET:
                begin
                    array_select_n_r <= 1'b0;
                    byte_data_oe_n_r <= 1'b1;
                    if (wait_r == 8'h00)
                    begin
                        read_select_n_r <= 1'b0;
                        wait_r          <= `READ_CYCLES;
                        state_r         <= S_RREAD;
                    end
                    else
                        wait_r <= wait_r - 8'h01;
                end
                S_RREAD:
                begin
                    if (wait_r == 8'h00)
                    begin
                        read_select_n_r <= 1'b1;
                        if (word_r && !second_r)
                            rdata_r[15:8] <= sampled_r;
                        else
                            rdata_r[7:0]  <= sampled_r;
                        state_r <= S_NEXT;
                    end
                    else
                        wait_r <= wait_r - 8'h01;
                end
                S_NEXT:
                begin
                    byte_data_oe_n_r <= 1'b1;
                    // failed upper byte aborts the word rather than half-write it
                    if (word_r && !second_r && !fail_r)
                    begin
                        second_r             <= 1'b1;
                        byte_address_lines_r <= {byte_address_lines_r[12:1], 1'b1};
                        target_r             <= lo_byte_r;
                        prime_count_r        <= 4'h0;
                        wait_r               <= `SETUP_CYCLES;
                        state_r              <= is_prog_r ? S_SETUP : S_RSET;
                    end
                    else
                    begin
                        array_select_n_r <= 1'b1;
                        done_r           <= 1'b1;
                        cmd_ready_r      <= 1'b1;
                        state_r          <= S_IDLE;
                    end
                end
                default:
                    state_r <= S_IDLE;
            endcase
        end
    end
endmodule

// [src/prog_port_consts.vh]
// timing and width constants for the byte-wide eprom programmer
// assumes a 100 MHz system clock
`ifndef PROG_PORT_CONSTS_VH
`define PROG_PORT_CONSTS_VH
`define CLK_MHZ          100
`define PRIME_PULSE_US   1000
`define FINAL_UNIT_US    4000
`define PRIME_CYCLES     (`PRIME_PULSE_US * `CLK_MHZ)
`define FINAL_CYCLES     (`FINAL_UNIT_US * `CLK_MHZ)
`define MAX_PRIME        4'hF
`define SETUP_CYCLES     8'h04
`define READ_CYCLES      8'h08
`define ADDR_W           13
`define DATA_W           8
`define ERASED_BYTE      8'hFF
`endif

// [src/pulse_timer.v]
// down-counter that times one strobe pulse
// assumes start is a registered one-cycle pulse, raised in the same cycle as the strobe falls
`timescale 1ns/1ns
module pulse_timer
(
    input  wire        clk,
    input  wire        resetn,
    input  wire        start,
    input  wire [31:0] length,
    output reg         busy_r
);
    reg [31:0] count_r;

    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            count_r <= 32'h0000_0000;
            busy_r  <= 1'b0;
        end
        else if (start)
        begin
            count_r <= length;
            busy_r  <= 1'b1;
        end
        else if (busy_r)
        begin
            // start lands a cycle late and the caller reacts a cycle late: end two counts early
            // limitation: lengths under three still give three cycles of strobe
            if (count_r <= 32'h0000_0003)
                busy_r <= 1'b0;
            count_r <= count_r - 32'h0000_0001;
        end
    end
endmodule

// [tb/eprom_device_model.sv]
// behavioural byte-wide eprom array seen from the programmer's pins
// assumes strobes only toggle from a registered host; need sets pulses to take
`timescale 1ns/1ns
module eprom_device_model
(
    input  wire [12:0] addr,
    input  wire [7:0]  din,
    input  wire        array_select_n,
    input  wire        read_select_n,
    input  wire        write_strobe_n,
    input  wire [4:0]  need,
    output wire [7:0]  q
);
    reg  [7:0]  mem [0:8191];
    integer     pulses [0:8191];
    reg  [7:0]  last_q;
    time        fall_t;
    time        width;
    integer     i;
    wire        drv;
    initial
    begin
        for (i = 0; i < 8192; i = i + 1)
        begin
            mem[i] = 8'hFF;
            pulses[i] = 0;
        end
        last_q = 8'h00;
        fall_t = 0;
        width = 0;
    end
    assign drv = !array_select_n && !read_select_n && write_strobe_n;
    // released lines show the inverse so stale data never passes a verify
    assign q = drv ? mem[addr] : ~last_q;
    always @*
        if (drv)
            last_q = mem[addr];
    always @(negedge write_strobe_n)
        fall_t = $time;
    always @(posedge write_strobe_n)
        if (!array_select_n && read_select_n)
        begin
            width = $time - fall_t;
            pulses[addr] = pulses[addr] + 1;
            // slow cells: bits only clear once enough pulses have landed
            if (pulses[addr] >= need)
                mem[addr] = mem[addr] & din;
        end
endmodule

// [tb/prog_checker_properties.sv]
// concurrent checks on the programmer's pins
// assumes bound to eprom_programmer, single clock domain
`timescale 1ns/1ns
module prog_checker
#(
    parameter PRIME_LEN = 20,
    parameter FINAL_LEN = 40
)
(
    input wire        clk,
    input wire        resetn,
    input wire        cmd_valid,
    input wire        cmd_ready_r,
    input wire        done_r,
    input wire        fail_r,
    input wire [12:0] byte_address_lines_r,
    input wire [7:0]  byte_data_out_r,
    input wire        byte_data_oe_n_r,
    input wire        array_select_n_r,
    input wire        read_select_n_r,
    input wire        write_strobe_n_r,
    input wire        test_mode_select_r,
    input wire        device_reset_input_r,
    input wire        oscillator_input_r
);
    reg [31:0] low_cnt_r;
    reg [4:0]  primes_r;
    reg [12:0] prime_addr_r;
    reg        ws_q_r;
    always @(posedge clk or negedge resetn)
        if (!resetn)
        begin
            low_cnt_r <= 32'h0000_0000;
            primes_r <= 5'h00;
            prime_addr_r <= 13'h0000;
            ws_q_r <= 1'b1;
        end
        else
        begin
            // previous strobe level, reset to idle high so no false rise follows reset
            ws_q_r <= write_strobe_n_r;
            low_cnt_r <= write_strobe_n_r ? 32'h0000_0000 : low_cnt_r + 32'h0000_0001;
            if (cmd_valid && cmd_ready_r)
                primes_r <= 5'h00;
            else if (write_strobe_n_r && !ws_q_r && low_cnt_r == PRIME_LEN)
            begin
                // new byte address restarts the count
                primes_r <= (byte_address_lines_r == prime_addr_r) ? primes_r + 5'h01 : 5'h01;
                prime_addr_r <= byte_address_lines_r;
            end
        end
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence prime_end;
        $rose(write_strobe_n_r) && low_cnt_r == PRIME_LEN;
    endsequence
    sequence verify_read;
        ##[1:30] !read_select_n_r;
    endsequence
    a_prog_levels: assert property (!write_strobe_n_r |->
        !array_select_n_r && read_select_n_r && !byte_data_oe_n_r) else $error("strobe low outside program mode");
    a_pins_stable: assert property (!write_strobe_n_r && !$past(write_strobe_n_r) |->
        $stable(byte_address_lines_r) && $stable(byte_data_out_r)) else $error("pins moved during strobe");
    a_prime_length: assert property ($rose(write_strobe_n_r) && low_cnt_r < FINAL_LEN |->
        low_cnt_r == PRIME_LEN) else $error("prime pulse length wrong");
    a_final_sized: assert property ($rose(write_strobe_n_r) && low_cnt_r > PRIME_LEN |->
        low_cnt_r == FINAL_LEN * primes_r) else $error("final pulse length wrong");
    a_verify_after: assert property (prime_end |-> verify_read) else $error("no verify after prime");
    a_prime_limit: assert property (primes_r <= 5'h0F) else $error("too many prime pulses");
    a_fail_exhaust: assert property (done_r && fail_r |-> primes_r == 5'h0F) else $error("early failure");
    a_read_float: assert property (!read_select_n_r |->
        byte_data_oe_n_r && !array_select_n_r && write_strobe_n_r) else $error("bad read levels");
    a_pins_tied: assert property (!test_mode_select_r && !device_reset_input_r
        && !oscillator_input_r) else $error("tied pin not low");
endmodule
bind eprom_programmer prog_checker #(.PRIME_LEN(PRIME_LEN), .FINAL_LEN(FINAL_LEN)) chk
(
    .clk(clk), .resetn(resetn), .cmd_valid(cmd_valid), .cmd_ready_r(cmd_ready_r), .done_r(done_r),
    .fail_r(fail_r), .byte_address_lines_r(byte_address_lines_r), .byte_data_out_r(byte_data_out_r),
    .byte_data_oe_n_r(byte_data_oe_n_r), .array_select_n_r(array_select_n_r),
    .read_select_n_r(read_select_n_r), .write_strobe_n_r(write_strobe_n_r),
    .test_mode_select_r(test_mode_select_r), .device_reset_input_r(device_reset_input_r),
    .oscillator_input_r(oscillator_input_r)
);

// [tb/tb.sv]
// self-checking bench: programmer against a behavioural eprom
// assumes short pulse lengths so the whole run stays brief
`timescale 1ns/1ns
module tb;
    localparam PRIME_LEN = 20;
    localparam FINAL_LEN = 40;
    typedef struct { logic [1:0] op; logic [12:0] addr; logic [15:0] data; logic [4:0] need;
                     logic [15:0] rdata; logic [3:0] cnt; logic fail; integer width; } row_t;
    reg         clk;
    reg         resetn;
    reg         cmd_valid;
    reg  [1:0]  cmd_op;
    reg  [12:0] cmd_addr;
    reg  [15:0] cmd_data;
    reg  [4:0]  need;
    wire        cmd_ready_r;
    wire        done_r;
    wire        fail_r;
    wire [15:0] rdata_r;
    wire [3:0]  prime_count_r;
    wire [12:0] addr_lines;
    wire [7:0]  data_out;
    wire        data_oe_n;
    wire [7:0]  data_lines;
    wire [7:0]  dev_q;
    wire        sel_n;
    wire        rd_n;
    wire        ws_n;
    integer     n_errors;
    integer     n_compared;
    integer     k;
    row_t       rows [0:8];
    assign data_lines = data_oe_n ? dev_q : data_out;
    eprom_programmer #(.PRIME_LEN(PRIME_LEN), .FINAL_LEN(FINAL_LEN)) uut
    (
        .clk(clk), .resetn(resetn), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
        .cmd_data(cmd_data), .cmd_ready_r(cmd_ready_r), .done_r(done_r), .fail_r(fail_r), .rdata_r(rdata_r),
        .prime_count_r(prime_count_r), .byte_address_lines_r(addr_lines), .byte_data_out_r(data_out),
        .byte_data_oe_n_r(data_oe_n), .byte_data_lines_in(data_lines), .array_select_n_r(sel_n),
        .read_select_n_r(rd_n), .write_strobe_n_r(ws_n), .test_mode_select_r(), .device_reset_input_r(),
        .oscillator_input_r()
    );
    eprom_device_model dev
    (
        .addr(addr_lines), .din(data_lines), .array_select_n(sel_n), .read_select_n(rd_n),
        .write_strobe_n(ws_n), .need(need), .q(dev_q)
    );
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task check(input string what, input [31:0] seen, input [31:0] exp);
    begin
        n_compared = n_compared + 1;
        if (seen !== exp)
        begin
            n_errors = n_errors + 1;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    end
    endtask
    task tally_and_finish;
    begin
        if (n_errors == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    end
    endtask
    task run_cmd(input [1:0] op, input [12:0] a, input [15:0] d);
        integer t;
    begin
        @(posedge clk);
        cmd_op <= op;
        cmd_addr <= a;
        cmd_data <= d;
        cmd_valid <= 1'b1;
        do @(posedge clk); while (cmd_ready_r !== 1'b1);
        cmd_valid <= 1'b0;
        t = 0;
        while (done_r !== 1'b1 && t < 5000)
        begin
            @(posedge clk);
            t = t + 1;
        end
        check("done", done_r, 1'b1);
    end
    endtask
    initial
    begin
        #400000;
        n_errors = n_errors + 1;
        tally_and_finish;
    end
    initial
    begin
        resetn = 1'b0;
        cmd_valid = 1'b0;
        cmd_op = 2'h0;
        cmd_addr = 13'h0000;
        cmd_data = 16'h0000;
        need = 5'h01;
        n_errors = 0;
        n_compared = 0;
        rows[0] = '{2'h1, 13'h0005, 16'h0000, 5'h01, 16'h00FF, 4'h0, 1'b0, 0};
        rows[1] = '{2'h0, 13'h1FFF, 16'h00A5, 5'h01, 16'h0000, 4'h1, 1'b0, 40};
        rows[2] = '{2'h1, 13'h1FFF, 16'h0000, 5'h01, 16'h00A5, 4'h0, 1'b0, 0};
        rows[3] = '{2'h0, 13'h0003, 16'h000F, 5'h03, 16'h0000, 4'h3, 1'b0, 120};
        rows[4] = '{2'h0, 13'h0003, 16'h00F0, 5'h01, 16'h0000, 4'hF, 1'b1, 20};
        rows[5] = '{2'h1, 13'h0003, 16'h0000, 5'h01, 16'h0000, 4'h0, 1'b0, 0};
        rows[6] = '{2'h2, 13'h0010, 16'h1234, 5'h01, 16'h0000, 4'h1, 1'b0, 40};
        rows[7] = '{2'h3, 13'h0010, 16'h0000, 5'h01, 16'h1234, 4'h0, 1'b0, 0};
        rows[8] = '{2'h0, 13'h0100, 16'h003C, 5'h10, 16'h0000, 4'hF, 1'b1, 20};
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        for (k = 0; k < 9; k = k + 1)
        begin
            need <= rows[k].need;
            run_cmd(rows[k].op, rows[k].addr, rows[k].data);
            check("fail", fail_r, rows[k].fail);
            if (rows[k].op[0])
                check("rdata", rdata_r & (rows[k].op[1] ? 16'hFFFF : 16'h00FF), rows[k].rdata);
            else
                check("primes", prime_count_r, rows[k].cnt);
            if (rows[k].width != 0)
                check("width", 32'(dev.width), rows[k].width * 10);
        end
        check("pulses", dev.pulses[13'h0100], 15);
        // reset lands one cycle into a prime pulse; valid left high to be ignored while busy
        need <= 5'h10;
        cmd_op <= 2'h0;
        cmd_addr <= 13'h0200;
        cmd_data <= 16'h0055;
        cmd_valid <= 1'b1;
        k = 0;
        while (ws_n !== 1'b0 && k < 100)
        begin
            @(posedge clk);
            k = k + 1;
        end
        cmd_valid <= 1'b0;
        resetn <= 1'b0;
        @(negedge clk);
        check("idle", {cmd_ready_r, sel_n, rd_n, ws_n, data_oe_n}, 5'h1F);
        @(posedge clk);
        resetn <= 1'b1;
        run_cmd(2'h1, 13'h1FFF, 16'h0000);
        check("reread", rdata_r[7:0], 8'hA5);
        tally_and_finish;
    end
endmodule
